// File: include/cir_pkg.sv
// constants and carrier types for the can control and interrupt registers
package cir_pkg;
  // register byte offsets on apb
  localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFF_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFF_INT_CODE    = 8'h08;
  localparam logic [7:0] OFF_FIFO_CTRL   = 8'h0C;
  localparam logic [7:0] OFF_FIFO_STAT   = 8'h10;
  localparam logic [7:0] OFF_INT_FLAGS   = 8'h14;
  localparam logic [7:0] OFF_INT_ENABLES = 8'h18;
  // control_one fields
  localparam int B_STOP_IDLE = 13;
  localparam int B_ABORT     = 12;
  localparam int B_REQ_LO    = 8;
  localparam int B_CUR_LO    = 5;
  localparam int B_CAPTURE   = 3;
  localparam int B_WINDOW    = 0;
  // fifo_control, fifo_status and interrupt code fields
  localparam int B_BUFCNT_LO = 13;
  localparam int B_WPTR_LO   = 8;
  localparam int B_FILTER_HIT_NUMBER_LO = 8;
  // interrupt flag positions
  localparam int F_INVALID = 7;
  localparam int F_WAKEUP  = 6;
  localparam int F_ERROR   = 5;
  localparam int F_FIFO    = 3;
  localparam int F_OVFL    = 2;
  localparam int F_RXDONE  = 1;
  localparam int F_TXDONE  = 0;
  localparam int B_ERRST_LO = 8;
  localparam logic [7:0] FLAG_MASK = 8'hEF;
  // operating modes
  typedef enum logic [2:0] {
    CIR_NORMAL   = 3'h0,
    CIR_DISABLE  = 3'h1,
    CIR_LOOPBACK = 3'h2,
    CIR_LISTEN   = 3'h3,
    CIR_CONFIG   = 3'h4,
    CIR_RSVD5    = 3'h5,
    CIR_RSVD6    = 3'h6,
    CIR_LISTEN_ALL = 3'h7
  } cir_mode_t;
  localparam logic [2:0] BUFCNT_RSVD = 3'h7;
  localparam logic [4:0] NETCMP_MAX  = 5'h11;
  // interrupt codes
  localparam logic [6:0] IC_NONE    = 7'h40;
  localparam logic [6:0] IC_ERROR   = 7'h41;
  localparam logic [6:0] IC_WAKEUP  = 7'h42;
  localparam logic [6:0] IC_OVFL    = 7'h43;
  localparam logic [6:0] IC_FIFO    = 7'h44;
  localparam logic [6:0] IC_INVALID = 7'h40;
  localparam int NUM_BUF_IRQ = 16;
  localparam int NUM_TX_BUF  = 8;
  // idle bus length, counted by the protocol engine
  localparam int BUS_IDLE_BITS = 11;
  // events from the protocol engine, one-cycle pulses except filter_hit and buf_num
  typedef struct packed {
    logic       invalid_msg;
    logic       wakeup;
    logic       fifo_almost_full;
    logic       rx_overflow;
    logic       msg_received;
    logic       buf_done;
    logic [3:0] buf_num;
    logic       fifo_written;
    logic       fifo_read;
    logic [4:0] filter_hit;
  } cir_evt_t;
  // error states from the protocol engine, levels
  typedef struct packed {
    logic tx_off;
    logic tx_passive;
    logic rx_passive;
    logic tx_warning;
    logic rx_warning;
  } cir_err_t;
endpackage : cir_pkg

// File: design/cir_regs.sv
// apb register set: mode control, fifo pointers and interrupt flags
//
// Behaviour
// - stop-in-idle halts module during cpu idle
// - abort bit aborts all tx, self-clears
// - requested mode codes; reserved codes ignored
// - current mode field reports mode in effect
// - mode changes only when bus idle
// - configuration writes only accepted in configuration mode
// - capture enable makes receive capture events
// - window select chooses filter or buffer map
// - five-bit data compare length setting
// - filter hit number of accepting filter
// - interrupt code for non-buffer sources
// - interrupt codes for buffers zero to fifteen
// - buffer count selects buffers in ram
// - fifo start names first fifo buffer
// - write pointer shows next fifo write
// - read pointer shows next fifo read
// - read-only error state bits
// - error flag set by error states
// - hardware sets flags, software only clears
// - fifo almost full and overflow flags
// - enable bit per flag, same position
module cir_regs (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cpu_idle,
  input  wire logic              bus_idle,
  input  wire logic              tx_all_aborted,
  input  cir_pkg::cir_evt_t      evt,
  input  cir_pkg::cir_err_t      err_state,
  output logic                   module_run,
  output logic                   abort_all_tx,
  output logic      [2:0]        current_mode,
  output logic                   map_window_select,
  output logic                   capture_event,
  output logic      [4:0]        net_compare_length,
  output logic      [2:0]        buffer_count_select,
  output logic                   irq
);
  // one pending bit per buffer that can raise a code
  localparam int NUM_BUF_IRQ_W = cir_pkg::NUM_BUF_IRQ;
  logic             stop_in_idle;
  logic [2:0]       requested_mode;
  logic             rx_capture_enable;
  logic [4:0]       fifo_start_buffer;
  logic [5:0]       fifo_write_pointer;
  logic [5:0]       fifo_read_pointer;
  logic [4:0]       filter_hit_number;
  logic [6:0]       interrupt_code;
  logic [5:0]       err_bits;
  logic [5:0]       err_prev;
  logic [7:0]       flags;
  logic [7:0]       enables;
  logic [NUM_BUF_IRQ_W-1:0] buf_pend;
  logic             access;
  logic             wr_en;
  logic             wr_lo;
  logic             wr_hi;
  logic             cfg_mode;
  logic [5:0]       last_buf;
  logic [5:0]       next_wptr;
  logic [5:0]       next_rptr;
  logic [7:0]       flag_set;
  logic [7:0]       pending;
  logic [6:0]       next_code;
  logic [31:0]      next_rdata;
  logic             hit_map;

  // byte-lane write strobes, taken at the pready edge
  assign access   = psel & penable;
  assign wr_en    = access & pready & pwrite;
  assign wr_lo    = wr_en & pstrb[0];
  assign wr_hi    = wr_en & pstrb[1];
  assign cfg_mode = current_mode == cir_pkg::CIR_CONFIG;

  // apb handshake: one wait state, answer on second access cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~hit_map;
      prdata  <= (access & ~pready & ~pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    hit_map    = 1'b1;
    case (paddr)
      cir_pkg::OFF_CONTROL_ONE: begin
        next_rdata[cir_pkg::B_STOP_IDLE] = stop_in_idle;
        next_rdata[cir_pkg::B_ABORT]     = abort_all_tx;
        next_rdata[cir_pkg::B_REQ_LO +: 3] = requested_mode;
        next_rdata[cir_pkg::B_CUR_LO +: 3] = current_mode;
        next_rdata[cir_pkg::B_CAPTURE]   = rx_capture_enable;
        next_rdata[cir_pkg::B_WINDOW]    = map_window_select;
      end
      cir_pkg::OFF_CONTROL_TWO: next_rdata[4:0] = net_compare_length;
      cir_pkg::OFF_INT_CODE: begin
        next_rdata[cir_pkg::B_FILTER_HIT_NUMBER_LO +: 5] = filter_hit_number;
        next_rdata[6:0] = interrupt_code;
      end
      cir_pkg::OFF_FIFO_CTRL: begin
        next_rdata[cir_pkg::B_BUFCNT_LO +: 3] = buffer_count_select;
        next_rdata[4:0] = fifo_start_buffer;
      end
      cir_pkg::OFF_FIFO_STAT: begin
        next_rdata[cir_pkg::B_WPTR_LO +: 6] = fifo_write_pointer;
        next_rdata[5:0] = fifo_read_pointer;
      end
      cir_pkg::OFF_INT_FLAGS: begin
        next_rdata[cir_pkg::B_ERRST_LO +: 6] = err_bits;
        next_rdata[7:0] = flags;
      end
      cir_pkg::OFF_INT_ENABLES: next_rdata[7:0] = enables;
      default: hit_map = 1'b0;
    endcase
  end

  // requested mode, always writable so configuration can be left
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      requested_mode <= cir_pkg::CIR_CONFIG;
    end else if (wr_hi && paddr == cir_pkg::OFF_CONTROL_ONE &&
                 pwdata[cir_pkg::B_REQ_LO +: 3] != cir_pkg::CIR_RSVD5 &&
                 pwdata[cir_pkg::B_REQ_LO +: 3] != cir_pkg::CIR_RSVD6) begin
      requested_mode <= pwdata[cir_pkg::B_REQ_LO +: 3];
    end
  end

  // mode switch waits for the engine's idle-bus indication
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      current_mode <= cir_pkg::CIR_CONFIG;
    end else if (bus_idle && current_mode != requested_mode) begin
      current_mode <= requested_mode;
    end
  end

  // abort: software sets, hardware clears; a set beats the clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      abort_all_tx <= 1'b0;
    end else if (wr_hi && paddr == cir_pkg::OFF_CONTROL_ONE &&
                 pwdata[cir_pkg::B_ABORT]) begin
      abort_all_tx <= 1'b1;
    end else if (tx_all_aborted) begin
      abort_all_tx <= 1'b0;
    end
  end

  // locked control bits
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stop_in_idle      <= 1'b0;
      rx_capture_enable <= 1'b0;
    end else if (cfg_mode && paddr == cir_pkg::OFF_CONTROL_ONE) begin
      if (wr_hi) begin
        stop_in_idle <= pwdata[cir_pkg::B_STOP_IDLE];
      end
      if (wr_lo) begin
        rx_capture_enable <= pwdata[cir_pkg::B_CAPTURE];
      end
    end
  end

  // window select stays writable so filters can be reached
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      map_window_select <= 1'b0;
    end else if (wr_lo && paddr == cir_pkg::OFF_CONTROL_ONE) begin
      map_window_select <= pwdata[cir_pkg::B_WINDOW];
    end
  end

  // invalid compare lengths leave the old value
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      net_compare_length <= 5'h00;
    end else if (cfg_mode && wr_lo && paddr == cir_pkg::OFF_CONTROL_TWO &&
                 pwdata[4:0] <= cir_pkg::NETCMP_MAX) begin
      net_compare_length <= pwdata[4:0];
    end
  end

  // buffer count and fifo start, configuration only
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      buffer_count_select <= 3'h0;
      fifo_start_buffer   <= 5'h00;
    end else if (cfg_mode && paddr == cir_pkg::OFF_FIFO_CTRL) begin
      if (wr_hi &&
          pwdata[cir_pkg::B_BUFCNT_LO +: 3] != cir_pkg::BUFCNT_RSVD) begin
        buffer_count_select <= pwdata[cir_pkg::B_BUFCNT_LO +: 3];
      end
      if (wr_lo) begin
        fifo_start_buffer <= pwdata[4:0];
      end
    end
  end

  // module run and capture outputs
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      module_run    <= 1'b1;
      capture_event <= 1'b0;
    end else begin
      module_run    <= ~(stop_in_idle & cpu_idle);
      capture_event <= rx_capture_enable & evt.msg_received;
    end
  end

  // last buffer held in ram for the chosen count
  always_comb begin
    case (buffer_count_select)
      3'h0:    last_buf = 6'h03;
      3'h1:    last_buf = 6'h05;
      3'h2:    last_buf = 6'h07;
      3'h3:    last_buf = 6'h0B;
      3'h4:    last_buf = 6'h0F;
      3'h5:    last_buf = 6'h17;
      default: last_buf = 6'h1F;
    endcase
  end

  // fifo pointers wrap from the last buffer back to the fifo start
  always_comb begin
    next_wptr = (fifo_write_pointer >= last_buf) ? {1'b0, fifo_start_buffer}
                : fifo_write_pointer + 6'h01;
    next_rptr = (fifo_read_pointer >= last_buf) ? {1'b0, fifo_start_buffer}
                : fifo_read_pointer + 6'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fifo_write_pointer <= 6'h00;
      fifo_read_pointer  <= 6'h00;
    end else if (cfg_mode) begin
      fifo_write_pointer <= {1'b0, fifo_start_buffer};
      fifo_read_pointer  <= {1'b0, fifo_start_buffer};
    end else begin
      if (evt.fifo_written) begin
        fifo_write_pointer <= next_wptr;
      end
      if (evt.fifo_read) begin
        fifo_read_pointer <= next_rptr;
      end
    end
  end

  // filter hit latched with each received message
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      filter_hit_number <= 5'h00;
    end else if (evt.msg_received) begin
      filter_hit_number <= evt.filter_hit;
    end
  end

  // error state bits, combined warning in the lowest position
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      err_bits <= 6'h00;
      err_prev <= 6'h00;
    end else begin
      err_bits <= {err_state.tx_off, err_state.tx_passive,
                   err_state.rx_passive, err_state.tx_warning,
                   err_state.rx_warning,
                   err_state.tx_warning | err_state.rx_warning};
      err_prev <= err_bits;
    end
  end

  // hardware set sources
  always_comb begin
    flag_set = 8'h00;
    flag_set[cir_pkg::F_INVALID] = evt.invalid_msg;
    flag_set[cir_pkg::F_WAKEUP]  = evt.wakeup;
    flag_set[cir_pkg::F_ERROR]   = |(err_bits & ~err_prev);
    flag_set[cir_pkg::F_FIFO]    = evt.fifo_almost_full;
    flag_set[cir_pkg::F_OVFL]    = evt.rx_overflow;
    flag_set[cir_pkg::F_RXDONE]  = evt.buf_done &
                                   evt.buf_num >= 4'(cir_pkg::NUM_TX_BUF);
    flag_set[cir_pkg::F_TXDONE]  = evt.buf_done &
                                   evt.buf_num < 4'(cir_pkg::NUM_TX_BUF);
  end

  // writing zero clears a flag; a simultaneous set wins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      flags <= 8'h00;
    end else if (wr_lo && paddr == cir_pkg::OFF_INT_FLAGS) begin
      flags <= ((flags & pwdata[7:0]) | flag_set) & cir_pkg::FLAG_MASK;
    end else begin
      flags <= (flags | flag_set) & cir_pkg::FLAG_MASK;
    end
  end

  // enables locked with the rest of the configuration
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      enables <= 8'h00;
    end else if (cfg_mode && wr_lo && paddr == cir_pkg::OFF_INT_ENABLES) begin
      enables <= pwdata[7:0] & cir_pkg::FLAG_MASK;
    end
  end

  // per-buffer pending, dropped when its tx or rx flag is cleared
  genvar gi;
  generate
    for (gi = 0; gi < cir_pkg::NUM_BUF_IRQ; gi++) begin : g_buf
      localparam int FI = (gi < cir_pkg::NUM_TX_BUF) ? cir_pkg::F_TXDONE
                                                     : cir_pkg::F_RXDONE;
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          buf_pend[gi] <= 1'b0;
        end else if (evt.buf_done && evt.buf_num == 4'(gi)) begin
          buf_pend[gi] <= 1'b1;
        end else if (!flags[FI]) begin
          buf_pend[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // highest priority: error, wakeup, overflow, fifo, then lowest buffer
  always_comb begin
    pending   = flags & enables;
    next_code = cir_pkg::IC_NONE;
    if (pending[cir_pkg::F_ERROR]) begin
      next_code = cir_pkg::IC_ERROR;
    end else if (pending[cir_pkg::F_WAKEUP]) begin
      next_code = cir_pkg::IC_WAKEUP;
    end else if (pending[cir_pkg::F_OVFL]) begin
      next_code = cir_pkg::IC_OVFL;
    end else if (pending[cir_pkg::F_FIFO]) begin
      next_code = cir_pkg::IC_FIFO;
    end else begin
      for (int i = cir_pkg::NUM_BUF_IRQ - 1; i >= 0; i--) begin
        if (buf_pend[i] &&
            pending[(i < cir_pkg::NUM_TX_BUF) ? cir_pkg::F_TXDONE
                                              : cir_pkg::F_RXDONE]) begin
          next_code = 7'(i);
        end
      end
    end
  end

  // code and request registered for the cpu side
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      interrupt_code <= cir_pkg::IC_NONE;
      irq            <= 1'b0;
    end else begin
      interrupt_code <= next_code;
      irq            <= |pending;
    end
  end

endmodule : cir_regs

// File: test/cir_regs_properties.sv
// port checker for the can control and interrupt register block
module cir_regs_properties (
  input wire logic         sys_clk,
  input wire logic         nrst,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         cpu_idle,
  input wire logic         bus_idle,
  input wire logic         tx_all_aborted,
  input cir_pkg::cir_evt_t evt,
  input wire logic         module_run,
  input wire logic         abort_all_tx,
  input wire logic [2:0]   current_mode,
  input wire logic         capture_event,
  input wire logic [4:0]   net_compare_length,
  input wire logic [2:0]   buffer_count_select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not one cycle after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_unmapped_err: assert property (psel && penable && !$past(penable)
    && paddr > 8'h18 |=> pready && pslverr)
    else $error("unmapped access without slave error");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data driven outside answer cycle");
  a_mode_wait: assert property (
    !$past(bus_idle) |-> $stable(current_mode))
    else $error("mode changed while bus busy");
  a_mode_legal: assert property (
    current_mode != 3'h5 && current_mode != 3'h6)
    else $error("reserved current mode reported");
  a_run_awake: assert property (!cpu_idle |=> module_run)
    else $error("module halted while cpu awake");
  a_capture_cause: assert property (
    capture_event |-> $past(evt.msg_received))
    else $error("capture event without received message");
  a_abort_done: assert property (
    $fell(abort_all_tx) |-> $past(tx_all_aborted))
    else $error("abort cleared before all aborted");
  a_ncl_range: assert property (
    net_compare_length <= cir_pkg::NETCMP_MAX)
    else $error("compare length beyond maximum");
  a_bufcnt_legal: assert property (
    buffer_count_select != cir_pkg::BUFCNT_RSVD)
    else $error("reserved buffer count in effect");
endmodule : cir_regs_properties

bind cir_regs cir_regs_properties u_props (.sys_clk, .nrst, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .cpu_idle, .bus_idle, .tx_all_aborted,
  .evt, .module_run, .abort_all_tx, .current_mode, .capture_event,
  .net_compare_length, .buffer_count_select);

// File: test/cir_engine_model.sv
// protocol engine stand-in: bus idle detection and abort completion
module cir_engine_model (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic abort_all_tx,
  input  wire logic bus_quiet,
  output logic      bus_idle,
  output logic      tx_all_aborted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] quiet_bits;
  logic [2:0] abort_wait;

  // idle only after eleven quiet bit times in a row
  always_ff @(posedge sys_clk) begin
    if (!nrst || !bus_quiet) quiet_bits <= 4'h0;
    else if (quiet_bits != 4'hB) quiet_bits <= quiet_bits + 4'h1;
  end
  assign bus_idle = (quiet_bits == 4'hB);

  // pending transmissions take a few cycles to abandon
  always_ff @(posedge sys_clk) begin
    if (!nrst || !abort_all_tx) begin
      abort_wait     <= 3'h0;
      tx_all_aborted <= 1'h0;
    end else begin
      abort_wait     <= abort_wait + 3'h1;
      tx_all_aborted <= (abort_wait == 3'h3);
    end
  end
endmodule : cir_engine_model

// File: test/cir_regs_test.sv
// self-checking bench for the can control and interrupt registers
module cir_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk, nrst, psel, penable, pwrite, cpu_idle;
  logic              bus_quiet, pready, pslverr, bus_idle, tx_all_aborted;
  logic              module_run, abort_all_tx, map_window_select, irq;
  logic              capture_event, rerr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic [3:0]        pstrb;
  logic [2:0]        current_mode, buffer_count_select;
  logic [4:0]        net_compare_length;
  cir_pkg::cir_evt_t evt;
  cir_pkg::cir_err_t err_state;
  int                failures, checks_done, cycles;
  logic [2:0]        m_list [6] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h0};

  cir_regs dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_idle(cpu_idle), .bus_idle(bus_idle), .tx_all_aborted(tx_all_aborted),
    .evt(evt), .err_state(err_state), .module_run(module_run),
    .abort_all_tx(abort_all_tx), .current_mode(current_mode),
    .map_window_select(map_window_select), .capture_event(capture_event),
    .net_compare_length(net_compare_length),
    .buffer_count_select(buffer_count_select), .irq(irq));
  cir_engine_model u_eng (.sys_clk(sys_clk), .nrst(nrst),
    .abort_all_tx(abort_all_tx), .bus_quiet(bus_quiet), .bus_idle(bus_idle),
    .tx_all_aborted(tx_all_aborted));

  always #2.5 sys_clk = ~sys_clk;

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish;
    end
  end

  task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input string n);
    apb(1'h0, a, 32'h0);
    chk(n, exp, rdat);
  endtask : rd

  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  task pulse(input cir_pkg::cir_evt_t e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
  endtask : pulse

  task t_reset_values;
    logic [31:0] exp [7];
    exp = '{32'h0480, 32'h0, 32'h0040, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), exp[i], "reset value");
    end
    rd(8'h1C, 32'h0, "unmapped read");
    chk("unmapped error", 32'h1, {31'h0, rerr});
  endtask : t_reset_values

  task t_config_fields;
    wr(cir_pkg::OFF_CONTROL_TWO, 32'h11);
    rd(cir_pkg::OFF_CONTROL_TWO, 32'h11, "compare max");
    wr(cir_pkg::OFF_CONTROL_TWO, 32'h12);
    rd(cir_pkg::OFF_CONTROL_TWO, 32'h11, "compare invalid");
    chk("compare port", 32'h11, {27'h0, net_compare_length});
    wr(cir_pkg::OFF_FIFO_CTRL, 32'hC01F);
    rd(cir_pkg::OFF_FIFO_STAT, 32'h1F1F, "ptr at start");
    chk("buffer count", 32'h6, {29'h0, buffer_count_select});
    wr(cir_pkg::OFF_FIFO_CTRL, 32'h0001);
    rd(cir_pkg::OFF_FIFO_CTRL, 32'h0001, "fifo control");
    wr(cir_pkg::OFF_INT_ENABLES, 32'hFFFF);
    rd(cir_pkg::OFF_INT_ENABLES, 32'h00EF, "enables");
    wr(cir_pkg::OFF_CONTROL_ONE, 32'h0409);
    rd(cir_pkg::OFF_CONTROL_ONE, 32'h0489, "capture window");
    chk("window select", 32'h1, {31'h0, map_window_select});
    pulse('{msg_received: 1'h1, filter_hit: 5'h0F, default: '0});
    @(posedge sys_clk);
    chk("capture on", 32'h1, {31'h0, capture_event});
    rd(cir_pkg::OFF_INT_CODE, 32'h0F40, "filter hit");
    wr(cir_pkg::OFF_CONTROL_ONE, 32'h0400);
    pulse('{msg_received: 1'h1, filter_hit: 5'h0F, default: '0});
    @(posedge sys_clk);
    chk("capture off", 32'h0, {31'h0, capture_event});
    wr(cir_pkg::OFF_CONTROL_ONE, 32'h2400);
    cpu_idle <= 1'h1;
    idle(3);
    chk("halted in idle", 32'h0, {31'h0, module_run});
    wr(cir_pkg::OFF_CONTROL_ONE, 32'h0400);
    idle(3);
    chk("runs in idle", 32'h1, {31'h0, module_run});
    cpu_idle <= 1'h0;
  endtask : t_config_fields

  task t_flags;
    wr(cir_pkg::OFF_INT_FLAGS, 32'hFF);
    rd(cir_pkg::OFF_INT_FLAGS, 32'h0, "write one keeps");
    err_state <= '{tx_warning: 1'h1, default: '0};
    idle(4);
    rd(cir_pkg::OFF_INT_FLAGS, 32'h0520, "error state");
    pulse('{wakeup: 1'h1, default: '0});
    rd(cir_pkg::OFF_INT_FLAGS, 32'h0560, "wakeup flag");
    pstrb <= 4'h2;
    wr(cir_pkg::OFF_INT_FLAGS, 32'h0);
    rd(cir_pkg::OFF_INT_FLAGS, 32'h0560, "upper lane only");
    pstrb <= 4'hF;
    rd(cir_pkg::OFF_INT_CODE, 32'h0F41, "error first");
    wr(cir_pkg::OFF_INT_FLAGS, 32'h0);
    rd(cir_pkg::OFF_INT_FLAGS, 32'h0500, "cleared");
    rd(cir_pkg::OFF_INT_CODE, 32'h0F40, "no source");
    chk("irq quiet", 32'h0, {31'h0, irq});
    err_state <= '0;
    pulse('{buf_done: 1'h1, buf_num: 4'h9, default: '0});
    pulse('{buf_done: 1'h1, buf_num: 4'h2, default: '0});
    rd(cir_pkg::OFF_INT_FLAGS, 32'h0003, "buffer flags");
    rd(cir_pkg::OFF_INT_CODE, 32'h0F02, "lowest buffer");
    chk("irq up", 32'h1, {31'h0, irq});
    pulse('{rx_overflow: 1'h1, fifo_almost_full: 1'h1, default: '0});
    rd(cir_pkg::OFF_INT_FLAGS, 32'h000F, "fifo overflow");
    rd(cir_pkg::OFF_INT_CODE, 32'h0F43, "overflow code");
    wr(cir_pkg::OFF_INT_FLAGS, 32'hFB);
    rd(cir_pkg::OFF_INT_CODE, 32'h0F44, "fifo code");
    wr(cir_pkg::OFF_INT_ENABLES, 32'h0);
    idle(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(cir_pkg::OFF_INT_FLAGS, 32'h0);
    wr(cir_pkg::OFF_INT_ENABLES, 32'hEF);
    pulse('{invalid_msg: 1'h1, default: '0});
    idle(3);
    chk("irq invalid", 32'h1, {31'h0, irq});
    wr(cir_pkg::OFF_INT_FLAGS, 32'h0);
  endtask : t_flags

  task t_abort;
    int n;
    wr(cir_pkg::OFF_CONTROL_ONE, 32'h1400);
    @(posedge sys_clk);
    chk("abort raised", 32'h1, {31'h0, abort_all_tx});
    n = 0;
    while (abort_all_tx !== 1'h0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    rd(cir_pkg::OFF_CONTROL_ONE, 32'h0480, "abort cleared");
  endtask : t_abort

  task t_modes;
    logic [31:0] m;
    bus_quiet <= 1'h0;
    idle(2);
    wr(cir_pkg::OFF_CONTROL_ONE, 32'h0);
    idle(4);
    rd(cir_pkg::OFF_CONTROL_ONE, 32'h0080, "mode held");
    bus_quiet <= 1'h1;
    idle(14);
    rd(cir_pkg::OFF_CONTROL_ONE, 32'h0, "mode taken");
    chk("mode port", 32'h0, {29'h0, current_mode});
    wr(cir_pkg::OFF_FIFO_CTRL, 32'h0003);
    rd(cir_pkg::OFF_FIFO_CTRL, 32'h0001, "locked fifo");
    wr(cir_pkg::OFF_INT_ENABLES, 32'h0);
    rd(cir_pkg::OFF_INT_ENABLES, 32'hEF, "locked enables");
    repeat (2) pulse('{fifo_written: 1'h1, default: '0});
    rd(cir_pkg::OFF_FIFO_STAT, 32'h0301, "write pointer");
    pulse('{fifo_written: 1'h1, default: '0});
    rd(cir_pkg::OFF_FIFO_STAT, 32'h0101, "pointer wrap");
    pulse('{fifo_read: 1'h1, default: '0});
    rd(cir_pkg::OFF_FIFO_STAT, 32'h0102, "read pointer");
    foreach (m_list[i]) begin
      m = {29'h0, m_list[i]};
      wr(cir_pkg::OFF_CONTROL_ONE, m << 8);
      idle(3);
      rd(cir_pkg::OFF_CONTROL_ONE, m << 8 | m << 5, "mode code");
    end
    wr(cir_pkg::OFF_CONTROL_ONE, 32'h0500);
    idle(3);
    rd(cir_pkg::OFF_CONTROL_ONE, 32'h0, "reserved mode");
  endtask : t_modes

  initial begin
    sys_clk = 1'h0;
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    cpu_idle = 1'h0;
    bus_quiet = 1'h1;
    evt = '0;
    err_state = '0;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'h1;
    t_reset_values;
    t_config_fields;
    t_flags;
    t_abort;
    t_modes;
    tally_and_finish;
  end
endmodule : cir_regs_test
